// >>> logic/swc_sub_idle_wake.sv
// sub-idle and low-voltage sub-idle release logic with AXI4-Lite registers
//
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
// What this block does
// RL1: leave standby on any unmasked nonmaskable or maskable request, or any reset source.
// RL2: release happens whatever the priority of the waking request.
// RL3: interrupt release enters subclock mode, or low-voltage subclock mode from low-voltage.
// RL4: pll returns to its pre-entry state; stays stopped after low-voltage standby.
// RL5: a waking nonmaskable request is acknowledged on release, acceptance on or off.
// RL6: maskable wake with acceptance off: no ack, keep pending, resume prior code.
// RL7: maskable wake, higher priority in service: no ack, keep pending, resume service.
// RL8: maskable wake, only lower priority in service: acknowledge on release.
// RL9: a source disabled by its mask bit set to 1 never ends standby.
// RL10: exactly 12 subclock cycles pass from waking request to release.
// RL11: a retained request stays pending until normally accepted, no re-assertion needed.
module swc_sub_idle_wake
	import swc_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int IRQ_N = 9
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic aclk_en,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic nmi_pin,
	input wire logic watchdog_nonmaskable_request,
	input wire logic [7:0] external_irq_pins,
	input wire logic internal_irq_request,
	input wire logic [IRQ_N-1:0] irq_unmask,
	input wire logic [SWC_PRIO_W-1:0] wake_prio,
	input wire logic irq_accept_on,
	input wire logic isr_active,
	input wire logic [SWC_PRIO_W-1:0] isr_prio,
	input wire logic irq_taken,
	input wire logic reset_pin_n,
	input wire logic watchdog_reset_request,
	input wire logic low_voltage_detector_reset,
	input wire logic clock_monitor_reset,
	output logic cpu_stop,
	output logic sub_mode,
	output logic lv_sub_mode,
	output logic pll_run,
	output logic nmi_ack,
	output logic irq_ack,
	output logic irq_pending,
	output logic sys_reset_req
);
	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic [9:0] sync1_ff;
	logic [9:0] sync2_ff;
	// two flops for every pin before any logic looks at it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_ff <= 10'h200;
			sync2_ff <= 10'h200;
		end else if (aclk_en) begin
			sync1_ff <= {reset_pin_n, nmi_pin, external_irq_pins};
			sync2_ff <= sync1_ff;
		end
	end
	wire [7:0] ext_s = sync2_ff[7:0];
	wire nmi_s = sync2_ff[8];
	wire rst_pin_s = !sync2_ff[9];

	// ************************************************************
	// state and registers
	// ************************************************************
	swc_state_t st_ff;
	swc_state_t nxt_st;
	logic [3:0] cnt_ff;
	swc_mask_t mask_ff;
	logic lv_sel_ff, pll_cfg_ff, lv_ff, pll_saved_ff, cause_nmi_ff, pend_ff;
	logic enter_ff;
	logic aw_have_ff, w_have_ff;
	logic [ADDR_W-1:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;

	// ************************************************************
	// wake and reset decoding
	// ************************************************************
	// masked sources count as invalid and cannot wake the core
	wire [IRQ_N-1:0] irq_vec = IRQ_N'({internal_irq_request, ext_s});
	wire nmi_wake = (nmi_s && !mask_ff.pin_nmi_mask) ||
		(watchdog_nonmaskable_request && !mask_ff.wdt_nmi_mask); // RL9
	wire mask_wake = (|(irq_vec & irq_unmask)) && !mask_ff.int_mask; // RL9
	wire rst_any = rst_pin_s || watchdog_reset_request ||
		low_voltage_detector_reset || clock_monitor_reset;
	wire any_wake = nmi_wake || mask_wake;
	wire release_now = (st_ff == SWC_WAIT) && (cnt_ff == SWC_WAKE_LAST);
	// priority of waking request against the one in service
	wire ack_ok = irq_accept_on && (!isr_active || (wake_prio < isr_prio)); // RL7 RL8
	wire do_enter = (st_ff == SWC_RUN) && enter_ff && !rst_any;

	// ************************************************************
	// standby sequencer
	// ************************************************************
	// wake ignores priority; reset ends standby at once
	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			SWC_RUN: begin
				if (enter_ff && !rst_any) begin
					nxt_st = SWC_IDLE;
				end
			end
			SWC_IDLE: begin
				if (rst_any) begin
					nxt_st = SWC_RUN; // RL1
				end else if (any_wake) begin
					nxt_st = SWC_WAIT; // RL1 RL2
				end
			end
			SWC_WAIT: begin
				if (rst_any || release_now) begin
					nxt_st = SWC_RUN; // RL10
				end
			end
			default: begin
				nxt_st = SWC_RUN;
			end
		endcase
	end

	// state, latency counter and the context saved at entry
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff <= SWC_RUN;
			cnt_ff <= 4'h0;
			lv_ff <= 1'b0;
			pll_saved_ff <= 1'b0;
			cause_nmi_ff <= 1'b0;
		end else if (aclk_en) begin
			st_ff <= nxt_st;
			cnt_ff <= (st_ff == SWC_WAIT) ? cnt_ff + 4'h1 : 4'h0; // RL10
			if (do_enter) begin
				lv_ff <= lv_sel_ff;
				pll_saved_ff <= pll_cfg_ff;
			end
			if (st_ff == SWC_IDLE) begin
				cause_nmi_ff <= nmi_wake;
			end
		end
	end

	// outputs to core, clock control and interrupt controller
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cpu_stop <= 1'b0;
			sub_mode <= 1'b0;
			lv_sub_mode <= 1'b0;
			pll_run <= 1'b0;
			nmi_ack <= 1'b0;
			irq_ack <= 1'b0;
			pend_ff <= 1'b0;
			sys_reset_req <= 1'b0;
		end else if (aclk_en) begin
			cpu_stop <= (nxt_st != SWC_RUN);
			sys_reset_req <= rst_any;
			nmi_ack <= release_now && !rst_any && cause_nmi_ff; // RL5
			irq_ack <= release_now && !rst_any && !cause_nmi_ff && ack_ok; // RL8
			if (do_enter) begin
				pll_run <= 1'b0;
			end else if (release_now && !rst_any) begin
				sub_mode <= !lv_ff; // RL3
				lv_sub_mode <= lv_ff; // RL3
				pll_run <= !lv_ff && pll_saved_ff; // RL4
			end else if (wr_ctrl && st_ff == SWC_RUN) begin
				pll_run <= wdata_ff[SWC_CTRL_PLL_BIT]; // RL4
			end
			// retained request: set wins over the clear by irq_taken
			if (release_now && !rst_any && !cause_nmi_ff && !ack_ok) begin
				pend_ff <= 1'b1; // RL6 RL7
			end else if (irq_taken) begin
				pend_ff <= 1'b0; // RL11
			end
		end
	end
	assign irq_pending = pend_ff;

	// ************************************************************
	// AXI4-Lite slave
	// ************************************************************
	wire aw_hs = s_axi_awvalid && s_axi_awready;
	wire w_hs = s_axi_wvalid && s_axi_wready;
	wire wr_go = aw_have_ff && w_have_ff && !s_axi_bvalid;
	wire wr_ctrl = wr_go && (awaddr_ff == ADDR_W'(SWC_CTRL_OFS)) && wstrb_ff[0];
	wire wr_mask = wr_go && (awaddr_ff == ADDR_W'(SWC_MASK_OFS)) && wstrb_ff[0];
	wire wr_ok = (awaddr_ff == ADDR_W'(SWC_CTRL_OFS)) || (awaddr_ff == ADDR_W'(SWC_MASK_OFS));
	wire [31:0] stat_word = {24'h00_0000, pend_ff, lv_ff, cause_nmi_ff, lv_sub_mode,
		sub_mode, st_ff};
	wire [31:0] ctrl_word = {29'h0000_0000, pll_cfg_ff, lv_sel_ff, 1'b0};
	wire rd_ctrl = s_axi_araddr == ADDR_W'(SWC_CTRL_OFS);
	wire rd_mask = s_axi_araddr == ADDR_W'(SWC_MASK_OFS);
	wire rd_stat = s_axi_araddr == ADDR_W'(SWC_STAT_OFS);
	wire [31:0] rd_word = rd_ctrl ? ctrl_word :
		rd_mask ? {29'h0000_0000, mask_ff} : rd_stat ? stat_word : 32'h0000_0000;

	// write channel: address and data taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			aw_have_ff <= 1'b0;
			w_have_ff <= 1'b0;
			awaddr_ff <= '0;
			wdata_ff <= 32'h0000_0000;
			wstrb_ff <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= SWC_RESP_OKAY;
		end else if (aclk_en) begin
			if (aw_hs) begin
				aw_have_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (w_hs) begin
				w_have_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? SWC_RESP_OKAY : SWC_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_have_ff <= 1'b0;
				w_have_ff <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// control and mask registers; the enter bit is a self-clearing strobe
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mask_ff <= SWC_MASK_RST;
			lv_sel_ff <= 1'b0;
			pll_cfg_ff <= 1'b0;
			enter_ff <= 1'b0;
		end else if (aclk_en) begin
			enter_ff <= wr_ctrl && wdata_ff[SWC_CTRL_ENTER_BIT];
			if (wr_ctrl) begin
				lv_sel_ff <= wdata_ff[SWC_CTRL_LV_BIT];
				pll_cfg_ff <= wdata_ff[SWC_CTRL_PLL_BIT];
			end
			if (wr_mask) begin
				mask_ff.pin_nmi_mask <= wdata_ff[SWC_MASK_PIN_NMI_BIT];
				mask_ff.wdt_nmi_mask <= wdata_ff[SWC_MASK_WDT_NMI_BIT];
				mask_ff.int_mask <= wdata_ff[SWC_MASK_INT_BIT];
			end
		end
	end

	// read channel: one cycle from address to data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= SWC_RESP_OKAY;
		end else if (aclk_en) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= (rd_ctrl || rd_mask || rd_stat) ? SWC_RESP_OKAY : SWC_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************
	a_wake_starts_wait: assert property (@(posedge aclk) disable iff (!aresetn) // RL1
		(aclk_en && st_ff == SWC_IDLE && any_wake && !rst_any) |=> st_ff == SWC_WAIT &&
		cnt_ff == 4'h0)
		else $error("wake request did not start the release wait");
	a_mask_blocks_wake: assert property (@(posedge aclk) disable iff (!aresetn) // RL9
		(aclk_en && st_ff == SWC_IDLE && !any_wake && !rst_any) |=> st_ff == SWC_IDLE)
		else $error("standby left without a valid source");
	a_reset_releases: assert property (@(posedge aclk) disable iff (!aresetn) // RL1
		(aclk_en && rst_any && st_ff != SWC_RUN) |=> (st_ff == SWC_RUN && sys_reset_req))
		else $error("reset source did not end standby");
	a_wait_twelve: assert property (@(posedge aclk) disable iff (!aresetn) // RL10
		(aclk_en && st_ff == SWC_WAIT && !rst_any) |=> (cnt_ff == $past(cnt_ff) + 4'h1) &&
		((st_ff == SWC_RUN) == ($past(cnt_ff) == SWC_WAKE_LAST)))
		else $error("release latency counter out of range");
	a_nmi_acked: assert property (@(posedge aclk) disable iff (!aresetn) // RL5
		(aclk_en && release_now && !rst_any && cause_nmi_ff) |=> nmi_ack && !irq_ack)
		else $error("waking nonmaskable request not acknowledged");
	a_di_retains: assert property (@(posedge aclk) disable iff (!aresetn) // RL6
		(aclk_en && release_now && !rst_any && !cause_nmi_ff && !irq_accept_on)
		|=> !irq_ack && pend_ff && !cpu_stop)
		else $error("request acknowledged with acceptance off");
	a_high_isr_holds: assert property (@(posedge aclk) disable iff (!aresetn) // RL7
		(aclk_en && release_now && !rst_any && !cause_nmi_ff && irq_accept_on &&
		isr_active && isr_prio <= wake_prio) |=> !irq_ack && pend_ff)
		else $error("request acknowledged over a higher priority service");
	a_low_isr_acks: assert property (@(posedge aclk) disable iff (!aresetn) // RL8
		(aclk_en && release_now && !rst_any && !cause_nmi_ff && irq_accept_on &&
		(!isr_active || wake_prio < isr_prio)) |=> irq_ack &&
		(pend_ff == ($past(pend_ff) && !$past(irq_taken))))
		else $error("waking request not acknowledged on release");
	a_mode_after: assert property (@(posedge aclk) disable iff (!aresetn) // RL3
		(aclk_en && release_now && !rst_any) |=> (lv_sub_mode == lv_ff) && (sub_mode != lv_ff))
		else $error("wrong operating mode after release");
	a_pll_restore: assert property (@(posedge aclk) disable iff (!aresetn) // RL4
		(aclk_en && release_now && !rst_any) |=> pll_run == (!lv_ff && pll_saved_ff))
		else $error("pll state wrong after release");
	a_pend_holds: assert property (@(posedge aclk) disable iff (!aresetn) // RL11
		(aclk_en && pend_ff && !irq_taken) |=> pend_ff)
		else $error("retained request dropped before acceptance");
endmodule

// >>> inc/swc_pkg.sv
// constants, register map and carrier types of the standby release logic
package swc_pkg;
	// ************************************************************
	// register map, byte addresses on the AXI4-Lite slave
	// ************************************************************
	localparam logic [7:0] SWC_CTRL_OFS = 8'h00;
	localparam logic [7:0] SWC_MASK_OFS = 8'h04;
	localparam logic [7:0] SWC_STAT_OFS = 8'h08;
	// control register fields
	localparam int SWC_CTRL_ENTER_BIT = 0;
	localparam int SWC_CTRL_LV_BIT = 1;
	localparam int SWC_CTRL_PLL_BIT = 2;
	// power_save_control_reg fields, a 1 disables the source
	localparam int SWC_MASK_PIN_NMI_BIT = 0;
	localparam int SWC_MASK_WDT_NMI_BIT = 1;
	localparam int SWC_MASK_INT_BIT = 2;
	localparam logic [2:0] SWC_MASK_RST = 3'h0;
	localparam logic [1:0] SWC_RESP_OKAY = 2'h0;
	localparam logic [1:0] SWC_RESP_SLVERR = 2'h2;
	// ************************************************************
	// timing: subclock cycles from wake request to release
	// ************************************************************
	localparam int SWC_WAKE_LAT = 12;
	localparam logic [3:0] SWC_WAKE_LAST = 4'(SWC_WAKE_LAT - 1);
	localparam int SWC_PRIO_W = 3;
	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [2:0] {
		SWC_RUN = 3'h1,
		SWC_IDLE = 3'h2,
		SWC_WAIT = 3'h4
	} swc_state_t;
	typedef struct packed {
		logic int_mask;
		logic wdt_nmi_mask;
		logic pin_nmi_mask;
	} swc_mask_t;
endpackage

// >>> bench/swc_cpu_model.sv
// cpu core model that later accepts a retained waking request
`timescale 1ns/1ns
module swc_cpu_model (
	input wire logic aclk,
	input wire logic irq_pending,
	input wire logic irq_accept_on,
	input wire logic isr_active,
	input wire logic [3:0] take_dly,
	output logic irq_taken
);
	int cnt = 0;
	// accept a pending request once acceptance is on and nothing is in service
	always @(posedge aclk) begin
		irq_taken <= 1'b0;
		cnt <= 0;
		if (irq_pending && irq_accept_on && !isr_active && !irq_taken) begin
			cnt <= cnt + 1;
			if (cnt >= int'(take_dly)) begin
				irq_taken <= 1'b1; // one-cycle take, then pending must drop
				cnt <= 0;
			end
		end
	end
endmodule

// >>> bench/test_sub_idle_wake_control.sv
// self-checking bench for the standby release logic
`timescale 1ns/1ns
module test_sub_idle_wake_control;
	import swc_pkg::*;
	logic aclk, aresetn, aclk_en, awvalid, wvalid, bready, arvalid, rready, ack;
	logic awready, wready, bvalid, arready, rvalid, nmi_pin, wdt_nmi, int_req;
	logic accept, isr_act, taken, rst_pin_n, wdt_rst, lvd_rst, clm_rst;
	logic cpu_stop, sub_m, lv_m, pll, nmi_ack, irq_ack, pend, sysrst;
	logic [7:0] awaddr, araddr, ext_pins;
	logic [31:0] wdata, rdata, d;
	logic [1:0] bresp, rresp, rs;
	logic [8:0] unmask;
	logic [2:0] wprio, iprio;
	logic [3:0] wstrb, take_dly;
	int n_mismatch = 0;
	int checks = 0;
	int k, n, src, lv, pl, ac, ia, wp, ip;
	// ************************************************************
	// design, cpu model and clock
	// ************************************************************
	swc_sub_idle_wake swc_sub_idle_wake_i (.aclk(aclk), .aresetn(aresetn), .aclk_en(aclk_en),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.nmi_pin(nmi_pin), .watchdog_nonmaskable_request(wdt_nmi),
		.external_irq_pins(ext_pins), .internal_irq_request(int_req), .irq_unmask(unmask),
		.wake_prio(wprio), .irq_accept_on(accept), .isr_active(isr_act), .isr_prio(iprio),
		.irq_taken(taken), .reset_pin_n(rst_pin_n), .watchdog_reset_request(wdt_rst),
		.low_voltage_detector_reset(lvd_rst), .clock_monitor_reset(clm_rst),
		.cpu_stop(cpu_stop), .sub_mode(sub_m), .lv_sub_mode(lv_m), .pll_run(pll),
		.nmi_ack(nmi_ack), .irq_ack(irq_ack), .irq_pending(pend), .sys_reset_req(sysrst));
	swc_cpu_model swc_cpu_model_i (.aclk(aclk), .irq_pending(pend), .irq_accept_on(accept),
		.isr_active(isr_act), .take_dly(take_dly), .irq_taken(taken));
	// free-running 250 MHz clock
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	// ************************************************************
	// checking, waiting and bus tasks
	// ************************************************************
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic fail_out(string what);
		n_mismatch++;
		$display("[FAIL] %s expected answer seen timeout", what);
		close_out();
	endtask
	task automatic chk(string what, logic [39:0] exp, logic [39:0] got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// count edges until a sampled output takes the wanted level
	task automatic wait_for(input logic want, ref logic sig, input int lim, output int cnt);
		for (cnt = 1; cnt <= lim; cnt++) begin
			@(posedge aclk);
			if (sig === want) return;
		end
		fail_out("wait");
	endtask
	// write: address and data offered together, each dropped once taken
	task automatic axi_wr(logic [7:0] a, logic [31:0] dv, logic [1:0] er);
		int i;
		@(posedge aclk);
		awaddr <= a;
		wdata <= dv;
		{awvalid, wvalid, bready} <= 3'h7;
		for (i = 0; i < 30; i++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		if (i == 30) fail_out("write");
		chk("bresp", er, bresp);
	endtask
	task automatic axi_rd(logic [7:0] a, output logic [31:0] dv, output logic [1:0] r);
		int i;
		@(posedge aclk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		for (i = 0; i < 30; i++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rready <= 1'b0;
		if (i == 30) fail_out("read");
		dv = rdata;
		r = rresp;
	endtask
	// request standby and wait until the core is stopped
	task automatic enter(int l, int p);
		int c;
		axi_wr(SWC_CTRL_OFS, {29'h0, 1'(p), 1'(l), 1'h1}, SWC_RESP_OKAY);
		wait_for(1'b1, cpu_stop, 20, c);
	endtask
	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		{aresetn, aclk_en, rst_pin_n, awvalid, wvalid, bready, arvalid, rready} = 8'h60;
		{nmi_pin, wdt_nmi, int_req, accept, isr_act, wdt_rst, lvd_rst, clm_rst} = 8'h00;
		{awaddr, araddr, ext_pins, wprio, iprio} = 30'h0;
		wdata = 32'h0;
		wstrb = 4'hf;
		unmask = 9'h1ff;
		take_dly = 4'h2;
		void'($urandom(22591));
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		// register access, read-only and unmapped places
		axi_rd(SWC_MASK_OFS, d, rs);
		chk("mask reset", {29'h0, SWC_MASK_RST}, d);
		axi_wr(SWC_MASK_OFS, 32'h0000_0006, SWC_RESP_OKAY);
		axi_rd(SWC_MASK_OFS, d, rs);
		chk("mask", 32'h0000_0006, d);
		axi_wr(SWC_STAT_OFS, 32'h0, SWC_RESP_SLVERR);
		axi_rd(8'h0c, d, rs);
		chk("unmapped", {SWC_RESP_SLVERR, 32'h0}, {rs, d});
		axi_wr(SWC_MASK_OFS, 32'h0, SWC_RESP_OKAY);
		$display("test registers done");
		// random wake sources, modes, acceptance and priorities
		for (k = 0; k < 40; k++) begin
			src = $urandom_range(3, 0);
			lv = $urandom_range(1, 0);
			pl = $urandom_range(1, 0);
			ac = $urandom_range(1, 0);
			ia = $urandom_range(1, 0);
			wp = $urandom_range(7, 0);
			ip = $urandom_range(7, 0);
			enter(lv, pl);
			accept <= 1'(ac);
			isr_act <= 1'(ia);
			wprio <= 3'(wp);
			iprio <= 3'(ip);
			take_dly <= 4'($urandom_range(9, 2));
			int_req <= (src == 0);
			ext_pins <= (src == 1) ? 8'h01 << $urandom_range(7, 0) : 8'h00;
			nmi_pin <= (src == 2);
			wdt_nmi <= (src == 3);
			wait_for(1'b0, cpu_stop, 40, n);
			ack = (src < 2) && ac != 0 && (ia == 0 || wp < ip);
			chk("latency", (src == 1 || src == 2) ? 16 : 14, n);
			chk("ack", {src > 1, ack}, {nmi_ack, irq_ack});
			chk("mode", {lv == 0, lv != 0, pl != 0 && lv == 0}, {sub_m, lv_m, pll});
			chk("pending", (src < 2) && !ack, pend);
			{int_req, ext_pins, nmi_pin, wdt_nmi} <= 11'h000;
			accept <= 1'b1;
			isr_act <= 1'b0;
			@(posedge aclk);
			chk("held", (src < 2) && !ack, pend);
			chk("pll kept", {lv == 0, pl != 0 && lv == 0}, {sub_m, pll});
			wait_for(1'b0, pend, 20, n);
		end
		axi_rd(SWC_STAT_OFS, d, rs);
		chk("status", {1'b0, lv != 0, lv == 0, 3'h1}, {d[7], d[4:0]});
		$display("test release done");
		// clock enable low freezes the release wait: four enabled edges, six frozen
		enter(0, 0);
		wdt_nmi <= 1'b1;
		repeat (4) @(posedge aclk);
		aclk_en <= 1'b0;
		repeat (6) @(posedge aclk);
		chk("frozen", 1, cpu_stop);
		aclk_en <= 1'b1;
		wdt_nmi <= 1'b0;
		wait_for(1'b0, cpu_stop, 40, n);
		chk("frozen latency", 10, n);
		chk("frozen ack", 2'h2, {nmi_ack, irq_ack});
		$display("test clock enable done");
		// masked sources stay asleep, then each reset source releases
		for (k = 0; k < 4; k++) begin
			axi_wr(SWC_MASK_OFS, (k < 3) ? 32'h0000_0001 << k : 32'h0, SWC_RESP_OKAY);
			unmask <= (k == 3) ? 9'h0ff : 9'h1ff;
			enter(0, 1);
			nmi_pin <= (k == 0);
			wdt_nmi <= (k == 1);
			int_req <= (k > 1);
			repeat (20) @(posedge aclk);
			chk("masked", 1, cpu_stop);
			{nmi_pin, wdt_nmi, int_req} <= 3'h0;
			rst_pin_n <= (k != 0);
			wdt_rst <= (k == 1);
			lvd_rst <= (k == 2);
			clm_rst <= (k == 3);
			wait_for(1'b0, cpu_stop, 8, n);
			chk("reset", 3'h4, {sysrst, nmi_ack, irq_ack});
			{rst_pin_n, wdt_rst, lvd_rst, clm_rst} <= 4'h8;
			repeat (5) @(posedge aclk);
		end
		$display("test masks and resets done");
		close_out();
	end
endmodule
